/* shared/cas_defs.svh */
`ifndef CAS_DEFS_SVH
`define CAS_DEFS_SVH

// Register indices; byte address is four times the index
`define CAS_IDX_THRS        8'h3b
`define CAS_IDX_CTRL        8'h3c
`define CAS_IDX_SCALE       8'h3d
`define CAS_IDX_AUTO        8'h3e

// Control register field positions
`define CAS_CTRL_OFS_LSB    0
`define CAS_CTRL_GRAD_LSB   8
`define CAS_CTRL_AUTOSCALE  18
`define CAS_CTRL_AUTOGRAD   19
`define CAS_CTRL_CHOP_EN    20

// Status field positions
`define CAS_SCALE_AUTO_LSB  16
`define CAS_GRAD_AUTO_LSB   16

// Reset values
`define CAS_CTRL_RESET      32'h0000_0000
`define CAS_THRS_RESET      8'h10
`define CAS_LEARN_RESET     8'h00

// Amplitude and timing figures
`define CAS_AMP_MAX         8'hff
`define CAS_CS_FULL         5'h1f
`define CAS_SCALE_LIM       9'h0ff
`define CAS_PWM_PERIOD      512
`define CAS_STEPS_PER_GRAD  3'h7

`endif

/* shared/cas_pkg.sv */
package cas_pkg;

    typedef logic [7:0]        cas_amp_t;
    typedef logic signed [8:0] cas_scale_t;

    // Regulator operating mode
    typedef enum logic [1:0] {
        CAS_MODE_FF,
        CAS_MODE_HOLD,
        CAS_MODE_RUN
    } cas_mode_t;

endpackage : cas_pkg

/* shared/cas_pwm_if.sv */
`timescale 1ns/1ps
interface cas_pwm_if;
    import cas_pkg::*;

    cas_amp_t   amplitude; // Regulated amplitude 0..255
    logic       enable;    // Silent chopper running
    logic       tick;      // One pulse per chopper period
    logic       pwm;       // Chopper output level
    logic [9:0] sum;       // Duty cycle sum, 10-bit

    modport ctrl (output amplitude, output enable,
                  input tick, input pwm, input sum);
    modport gen  (input amplitude, input enable,
                  output tick, output pwm, output sum);
endinterface : cas_pwm_if

/* verification/chopper_amplitude_autoscale_tb.sv */
`timescale 1ns/1ps
`include "cas_defs.svh"

`define CHECK_EQ(act, exp) \
    begin \
        samples_checked++; \
        if ((act) !== (exp)) \
        begin \
            errors++; \
            $display("[ERR] t=%0t got=%h exp=%h", $time, (act), (exp)); \
        end \
    end

module chopper_amplitude_autoscale_tb;
    import cas_pkg::*;

    // Short chopper period keeps the long settling waits cheap
    localparam int PER     = 8;
    localparam int CEILING = 20000;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ce = 1'b1;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [11:0] wb_adr = 12'h000;
    logic [3:0]  wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [4:0]  cs_actual = 5'h00;
    logic [19:0] step_period = 20'h00000;
    logic        standstill = 1'b0;
    logic        full_step = 1'b0;
    logic [7:0]  coil_meas = 8'h00;
    logic        pwm_out;
    logic        silent_en;
    int          errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    logic [31:0] rd;

    cas_regulator #(.PWM_PERIOD(PER)) cas_regulator_inst (
        .clk         (clk),
        .rst_n       (rst_n),
        .ce          (ce),
        .wb_cyc_i    (wb_cyc),
        .wb_stb_i    (wb_stb),
        .wb_we_i     (wb_we),
        .wb_adr_i    (wb_adr),
        .wb_sel_i    (wb_sel),
        .wb_dat_i    (wb_dat),
        .wb_dat_o    (wb_dat_o),
        .wb_ack_o    (wb_ack_o),
        .cs_actual   (cs_actual),
        .step_period (step_period),
        .standstill  (standstill),
        .full_step   (full_step),
        .coil_meas   (coil_meas),
        .pwm_out     (pwm_out),
        .silent_en   (silent_en)
    );

    // Free-running 25 MHz clock
    always #20 clk = ~clk;

    // Hang guard: a stuck handshake must not stall the run forever
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == CEILING)
        begin
            errors++;
            finish_test();
        end
    end

    // Classic single cycle; request held until ack is sampled high
    task automatic wb_xfer(input logic w, input logic [7:0] idx,
                           input logic [31:0] wd, output logic [31:0] q);
        q = 32'h0000_0000;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= w;
        wb_adr <= {2'b00, idx, 2'b00};
        wb_sel <= 4'hf;
        wb_dat <= wd;
        @(posedge clk);
        // Only the bench ceiling ends a wait for ack
        while (wb_ack_o !== 1'b1)
            @(posedge clk);
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask : wb_xfer

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] dummy;
        wb_xfer(1'b1, idx, d, dummy);
    endtask : wr

    function automatic logic [31:0] ctrl(input logic [7:0] ofs,
        input logic [7:0] grad, input logic as, input logic ag,
        input logic en);
        return {11'h000, en, ag, as, 2'b00, grad, ofs};
    endfunction : ctrl

    task automatic wait_ticks(input int n);
        repeat (n * PER) @(posedge clk);
    endtask : wait_ticks

    // Recommended order: offset first, then autoscale, then chopper
    task automatic start_auto(input logic [7:0] ofs, input logic [7:0] grad);
        wr(`CAS_IDX_CTRL, ctrl(ofs, grad, 1'b0, 1'b0, 1'b0));
        wr(`CAS_IDX_CTRL, ctrl(ofs, grad, 1'b1, 1'b0, 1'b0));
        wr(`CAS_IDX_CTRL, ctrl(ofs, grad, 1'b1, 1'b0, 1'b1));
    endtask : start_auto

    task automatic test_reset;
        wb_xfer(1'b0, `CAS_IDX_CTRL, 32'h0, rd);
        `CHECK_EQ(rd, 32'h0000_0000)
        wb_xfer(1'b0, `CAS_IDX_THRS, 32'h0, rd);
        `CHECK_EQ(rd, 32'h0000_0010)
        wb_xfer(1'b0, `CAS_IDX_SCALE, 32'h0, rd);
        `CHECK_EQ(rd, 32'h0000_0000)
        wb_xfer(1'b0, `CAS_IDX_AUTO, 32'h0, rd);
        `CHECK_EQ(rd, 32'h0000_0000)
        `CHECK_EQ({silent_en, pwm_out}, 2'b00)
        $display("test reset done");
    endtask : test_reset

    // Feed-forward amplitude over a table, including the clamp at 255
    task automatic test_feedforward;
        logic [7:0]  ofs[5]  = '{8'h00, 8'hff, 8'h40, 8'h80, 8'h80};
        logic [7:0]  grad[5] = '{8'h00, 8'hff, 8'h04, 8'h00, 8'h00};
        logic [4:0]  cs[5]   = '{5'h1f, 5'h1f, 5'h0f, 5'h00, 5'h1f};
        logic [19:0] sp[5]   = '{20'h0, 20'h1, 20'h40, 20'h0, 20'h0};
        logic [7:0]  amp[5]  = '{8'h00, 8'hff, 8'h30, 8'h04, 8'h80};
        int          highs;
        int          expect_h;
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk);
            cs_actual   <= cs[i];
            step_period <= sp[i];
            wr(`CAS_IDX_CTRL, ctrl(ofs[i], grad[i], 1'b0, 1'b0, 1'b1));
            wait_ticks(4);
            wb_xfer(1'b0, `CAS_IDX_SCALE, 32'h0, rd);
            `CHECK_EQ(rd[9:0], {amp[i], 2'b00})
            `CHECK_EQ(rd & 32'hfe00_fc00, 32'h0000_0000)
            `CHECK_EQ(silent_en, 1'b1)
            highs = 0;
            expect_h = 0;
            for (int c = 0; c < PER; c++)
                if (c * 256 < int'(amp[i]) * PER)
                    expect_h += 4;
            repeat (4 * PER)
            begin
                @(posedge clk);
                if (pwm_out === 1'b1)
                    highs++;
            end
            `CHECK_EQ(highs, expect_h)
        end
        $display("test feedforward done");
    endtask : test_feedforward

    // Writes to result registers and to an unmapped index change nothing
    task automatic test_readonly;
        wr(`CAS_IDX_SCALE, 32'hffff_ffff);
        wr(`CAS_IDX_AUTO, 32'hffff_ffff);
        wr(8'h20, 32'hffff_ffff);
        wb_xfer(1'b0, `CAS_IDX_SCALE, 32'h0, rd);
        `CHECK_EQ(rd[9:0], 10'h200)
        `CHECK_EQ(rd & 32'hfe00_fc00, 32'h0000_0000)
        wb_xfer(1'b0, `CAS_IDX_AUTO, 32'h0, rd);
        `CHECK_EQ(rd, 32'h0000_0000)
        wb_xfer(1'b0, 8'h20, 32'h0, rd);
        `CHECK_EQ(rd, 32'h0000_0000)
        wb_xfer(1'b0, `CAS_IDX_CTRL, 32'h0, rd);
        `CHECK_EQ(rd, ctrl(8'h80, 8'h00, 1'b0, 1'b0, 1'b1))
        $display("test readonly done");
    endtask : test_readonly

    // Seeding of tuning and gradient tracking; coil reads high throughout
    task automatic test_seed;
        @(posedge clk);
        cs_actual   <= 5'h00;
        step_period <= 20'h00000;
        coil_meas   <= 8'hff;
        wr(`CAS_IDX_CTRL, ctrl(8'h37, 8'h5a, 1'b0, 1'b0, 1'b0));
        wb_xfer(1'b0, `CAS_IDX_AUTO, 32'h0, rd);
        `CHECK_EQ(rd[23:16], 8'h5a)
        start_auto(8'h37, 8'h5a);
        wb_xfer(1'b0, `CAS_IDX_AUTO, 32'h0, rd);
        `CHECK_EQ(rd[7:0], 8'h37)
        $display("test seed done");
    endtask : test_seed

    // Zero offset floors at the threshold; nonzero offset goes below it
    task automatic test_floor;
        start_auto(8'h00, 8'h00);
        wait_ticks(300);
        wb_xfer(1'b0, `CAS_IDX_SCALE, 32'h0, rd);
        `CHECK_EQ(rd, 32'h0101_0040)
        wr(`CAS_IDX_THRS, 32'h0000_0020);
        wait_ticks(4);
        wb_xfer(1'b0, `CAS_IDX_SCALE, 32'h0, rd);
        `CHECK_EQ(rd[9:0], 10'h080)
        start_auto(8'h20, 8'h10);
        wait_ticks(300);
        wb_xfer(1'b0, `CAS_IDX_SCALE, 32'h0, rd);
        `CHECK_EQ(rd, 32'h0101_0000)
        wb_xfer(1'b0, `CAS_IDX_AUTO, 32'h0, rd);
        `CHECK_EQ(rd[7:0], 8'h20)
        // Status write while tuning must leave the learned values alone
        wr(`CAS_IDX_AUTO, 32'h0000_00ff);
        wb_xfer(1'b0, `CAS_IDX_AUTO, 32'h0, rd);
        `CHECK_EQ(rd, 32'h0010_0020)
        // Standstill tunes the offset down while the coil reads high
        standstill <= 1'b1;
        wait_ticks(40);
        wb_xfer(1'b0, `CAS_IDX_AUTO, 32'h0, rd);
        `CHECK_EQ(rd[7:0], 8'h00)
        standstill <= 1'b0;
        $display("test floor done");
    endtask : test_floor

    task automatic pulse_steps(input int n);
        repeat (n)
        begin
            @(posedge clk);
            full_step <= 1'b1;
            @(posedge clk);
            full_step <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask : pulse_steps

    // Gradient adapts one count per eight full steps while moving
    task automatic test_autograd;
        @(posedge clk);
        step_period <= 20'h10000;
        wr(`CAS_IDX_CTRL, ctrl(8'h20, 8'h10, 1'b1, 1'b1, 1'b1));
        pulse_steps(7);
        wb_xfer(1'b0, `CAS_IDX_AUTO, 32'h0, rd);
        `CHECK_EQ(rd[23:16], 8'h10)
        pulse_steps(1);
        wb_xfer(1'b0, `CAS_IDX_AUTO, 32'h0, rd);
        `CHECK_EQ(rd[23:16], 8'h0f)
        $display("test autograd done");
    endtask : test_autograd

    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    // Main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        test_reset();
        test_feedforward();
        test_readonly();
        test_seed();
        test_floor();
        test_autograd();
        finish_test();
    end

endmodule : chopper_amplitude_autoscale_tb

/* verilog/cas_ffamp.sv */
`timescale 1ns/1ps
`include "cas_defs.svh"
module cas_ffamp (
    input  wire logic            clk,         // System clock
    input  wire logic            rst_n,       // Async reset, active low
    input  wire logic            ce,          // Clock enable
    input  wire cas_pkg::cas_amp_t ofs,       // Offset operand
    input  wire logic [7:0]      grad,        // Gradient operand
    input  wire logic [4:0]      cs_actual,   // Actual current scale
    input  wire logic [19:0]     step_period, // Step period, 0 = stopped
    output cas_pkg::cas_amp_t    base         // Registered amplitude
);
    import cas_pkg::*;

    logic [13:0] ofs_prod;
    logic [19:0] grad_term;
    logic [20:0] total;

    // Offset scaled by (cs+1)/32 plus gradient*256/step period
    always_comb
    begin
        ofs_prod  = ofs * ({1'b0, cs_actual} + 6'h01);
        grad_term = (step_period == 20'h0_0000) ? 20'h0_0000
                  : {4'h0, grad, 8'h00} / step_period;
        total     = {12'h000, ofs_prod[12:5]} + {1'b0, grad_term};
    end

    // Limited to 0..255 as the amplitude cannot exceed full duty
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            base <= 8'h00;
        else if (ce)
            base <= (total > 21'h0000ff) ? `CAS_AMP_MAX : total[7:0];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_hold_scale: assert property (ce && step_period == 20'h0_0000 |=>
        base == $past(ofs_prod[12:5]))
        else $error("base does not follow offset times current scale");
endmodule : cas_ffamp

/* verilog/cas_pwmgen.sv */
`timescale 1ns/1ps
`include "cas_defs.svh"
module cas_pwmgen #(
    parameter int PERIOD = `CAS_PWM_PERIOD // Clocks per chopper period
) (
    input  wire logic clk,   // System clock
    input  wire logic rst_n, // Async reset, active low
    input  wire logic ce,    // Clock enable
    cas_pwm_if.gen    pif    // Amplitude in, chopper out
);
    import cas_pkg::*;

    logic [15:0] cnt;
    logic        wrap;

    assign wrap = (cnt == 16'(PERIOD - 1));

    // Free-running period counter, tick marks the period start
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
        begin
            cnt      <= 16'h0000;
            pif.tick <= 1'b0;
        end
        else if (ce)
        begin
            cnt      <= wrap ? 16'h0000 : cnt + 16'h0001;
            pif.tick <= wrap;
        end

    // Duty compare scaled so any period length is high for amplitude/256 of it, rounded up to whole clocks
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
        begin
            pif.pwm <= 1'b0;
            pif.sum <= 10'h000;
        end
        else if (ce)
        begin
            pif.pwm <= pif.enable &&
                ({8'h00, cnt} * 24'h000100) <
                ({16'h0000, pif.amplitude} * 24'(PERIOD));
            pif.sum <= {pif.amplitude, 2'b00};
        end
endmodule : cas_pwmgen

/* verilog/cas_regulator.sv */
`timescale 1ns/1ps
`include "cas_defs.svh"
module cas_regulator #(
    parameter int PWM_PERIOD = `CAS_PWM_PERIOD // Chopper period clocks
) (
    input  wire logic        clk,         // System clock, 25 MHz
    input  wire logic        rst_n,       // Async reset, active low
    input  wire logic        ce,          // Clock enable, freezes state
    input  wire logic        wb_cyc_i,    // Wishbone cycle
    input  wire logic        wb_stb_i,    // Wishbone strobe
    input  wire logic        wb_we_i,     // Wishbone write enable
    input  wire logic [11:0] wb_adr_i,    // Wishbone byte address
    input  wire logic [3:0]  wb_sel_i,    // Wishbone byte selects
    input  wire logic [31:0] wb_dat_i,    // Wishbone write data
    output logic      [31:0] wb_dat_o,    // Wishbone read data
    output logic             wb_ack_o,    // Wishbone acknowledge
    input  wire logic [4:0]  cs_actual,   // Actual current scale
    input  wire logic [19:0] step_period, // Step period, 0 = stopped
    input  wire logic        standstill,  // Motor at standstill
    input  wire logic        full_step,   // Pulse per full step
    input  wire logic [7:0]  coil_meas,   // Measured coil current
    output logic             pwm_out,     // Chopper drive to bridges
    output logic             silent_en    // Silent chopper enabled
);
    import cas_pkg::*;

    logic [31:0]     ctrl;
    cas_amp_t        lower_thr;
    cas_amp_t        user_amplitude_offset;
    logic [7:0]      user_gradient;
    logic            autoscale;
    logic            autograd;
    logic            autoscale_q;
    cas_mode_t       mode;
    cas_mode_t       next_mode;
    cas_scale_t      scale_auto;
    cas_amp_t        learned_offset;
    logic [7:0]      learned_gradient;
    logic [2:0]      step_cnt;
    cas_amp_t        base;
    cas_amp_t        ff_ofs;
    logic [7:0]      ff_grad;
    logic signed [10:0] raw_amp;
    cas_amp_t        clip_amp;
    cas_amp_t        next_amp;
    cas_amp_t        amp;
    logic [7:0]      target;
    logic            req;
    logic            wr;
    logic [7:0]      idx;

    cas_pwm_if pif ();

    assign user_amplitude_offset = ctrl[`CAS_CTRL_OFS_LSB +: 8];
    assign user_gradient         = ctrl[`CAS_CTRL_GRAD_LSB +: 8];
    assign autoscale             = ctrl[`CAS_CTRL_AUTOSCALE];
    assign autograd              = ctrl[`CAS_CTRL_AUTOGRAD];
    assign silent_en             = ctrl[`CAS_CTRL_CHOP_EN];

    // Bus decode; a write lands on the edge where ack is high
    assign req = wb_cyc_i && wb_stb_i;
    assign idx = wb_adr_i[9:2];
    assign wr  = req && wb_we_i && wb_ack_o && (wb_adr_i[11:10] == 2'b00);

    // Single-wait acknowledge, dropped the cycle after it is given
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            wb_ack_o <= 1'b0;
        else if (ce)
            wb_ack_o <= req && !wb_ack_o;

    // Control register written byte-lane by byte-lane
    for (genvar b = 0; b < 4; b++)
    begin : g_ctrl_lane
        always_ff @(posedge clk or negedge rst_n)
            if (!rst_n)
                ctrl[8*b +: 8] <= 8'(`CAS_CTRL_RESET >> (8*b));
            else if (ce && wr && idx == `CAS_IDX_CTRL && wb_sel_i[b])
                ctrl[8*b +: 8] <= wb_dat_i[8*b +: 8];
    end

    // Lower regulation threshold, used only with a zero offset
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            lower_thr <= `CAS_THRS_RESET;
        else if (ce && wr && idx == `CAS_IDX_THRS && wb_sel_i[0])
            lower_thr <= wb_dat_i[7:0];

    // Read data; status words ignore writes, unused bits are zero
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            wb_dat_o <= 32'h0000_0000;
        else if (ce && req && !wb_ack_o)
        begin
            if (wb_adr_i[11:10] != 2'b00)
                wb_dat_o <= 32'h0000_0000;
            else
                unique case (idx)
                    `CAS_IDX_THRS:  wb_dat_o <= {24'h00_0000, lower_thr};
                    `CAS_IDX_CTRL:  wb_dat_o <= ctrl;
                    `CAS_IDX_SCALE: wb_dat_o <= {7'h00, scale_auto,
                                                 6'h00, pif.sum};
                    `CAS_IDX_AUTO:  wb_dat_o <= {8'h00, learned_gradient,
                                                 8'h00, learned_offset};
                    default:        wb_dat_o <= 32'h0000_0000;
                endcase
        end

    // Mode follows autoscale and motion state
    always_comb
    begin
        if (!autoscale)
            next_mode = CAS_MODE_FF;
        else if (standstill)
            next_mode = CAS_MODE_HOLD;
        else
            next_mode = CAS_MODE_RUN;
    end

    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
        begin
            mode        <= CAS_MODE_FF;
            autoscale_q <= 1'b0;
        end
        else if (ce)
        begin
            mode        <= next_mode;
            autoscale_q <= autoscale;
        end

    // Target current from the actual scale; full scale is 31
    assign target = {cs_actual, 3'b111};

    // Closed-loop scale integrates the current error once per period
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            scale_auto <= 9'sh000;
        else if (ce)
        begin
            if (!autoscale)
                scale_auto <= 9'sh000;
            else if (pif.tick && target > coil_meas
                     && scale_auto != $signed(`CAS_SCALE_LIM))
                scale_auto <= scale_auto + 9'sh001;
            else if (pif.tick && target < coil_meas
                     && scale_auto != -$signed(`CAS_SCALE_LIM))
                scale_auto <= scale_auto - 9'sh001;
        end

    // Learned offset: seeded at enable, tuned in standstill
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            learned_offset <= `CAS_LEARN_RESET;
        else if (ce)
        begin
            if (autoscale && !autoscale_q)
                learned_offset <= user_amplitude_offset;
            else if (mode == CAS_MODE_HOLD && pif.tick)
            begin
                if (scale_auto > 9'sh000 && learned_offset != `CAS_AMP_MAX)
                    learned_offset <= learned_offset + 8'h01;
                else if (scale_auto < 9'sh000 && learned_offset != 8'h00)
                    learned_offset <= learned_offset - 8'h01;
            end
        end

    // Full-step count paces gradient adaptation
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            step_cnt <= 3'h0;
        else if (ce)
        begin
            if (mode != CAS_MODE_RUN || !autograd)
                step_cnt <= 3'h0;
            else if (full_step)
                step_cnt <= step_cnt + 3'h1;
        end

    // Gradient copies the user value or moves by one per 8 steps
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            learned_gradient <= `CAS_LEARN_RESET;
        else if (ce)
        begin
            if (!autograd)
                learned_gradient <= user_gradient;
            else if (mode == CAS_MODE_RUN && full_step
                     && step_cnt == `CAS_STEPS_PER_GRAD)
            begin
                if (scale_auto > 9'sh000 && learned_gradient != 8'hff)
                    learned_gradient <= learned_gradient + 8'h01;
                else if (scale_auto < 9'sh000 && learned_gradient != 8'h00)
                    learned_gradient <= learned_gradient - 8'h01;
            end
        end

    // Feed-forward operands: user values, or learned ones when tuning
    assign ff_ofs  = autoscale ? learned_offset : user_amplitude_offset;
    assign ff_grad = autoscale ? learned_gradient : user_gradient;

    cas_ffamp u_ffamp (
        .clk         (clk),
        .rst_n       (rst_n),
        .ce          (ce),
        .ofs         (ff_ofs),
        .grad        (ff_grad),
        .cs_actual   (cs_actual),
        .step_period (step_period),
        .base        (base)
    );

    // Amplitude select; the floor protects regulation at zero offset,
    // at the price of never powering down below it
    always_comb
    begin
        raw_amp  = $signed({3'b000, base}) + 11'(scale_auto);
        if (raw_amp < 11'sh000)
            clip_amp = 8'h00;
        else if (raw_amp > 11'sh0ff)
            clip_amp = `CAS_AMP_MAX;
        else
            clip_amp = raw_amp[7:0];
        if (!autoscale)
            next_amp = base;
        else if (user_amplitude_offset == 8'h00 && clip_amp < lower_thr)
            next_amp = lower_thr;
        else
            next_amp = clip_amp;
    end

    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            amp <= 8'h00;
        else if (ce)
            amp <= next_amp;

    assign pif.amplitude = amp;
    assign pif.enable    = silent_en;
    assign pwm_out       = pif.pwm;

    cas_pwmgen #(
        .PERIOD (PWM_PERIOD)
    ) u_pwmgen (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .pif   (pif)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_offset_write: assert property (ce && wr && idx == `CAS_IDX_CTRL
        && wb_sel_i[0] |=> user_amplitude_offset == $past(wb_dat_i[7:0]))
        else $error("offset write not stored");
    a_seed_offset: assert property (ce && autoscale && !autoscale_q
        |=> learned_offset == $past(user_amplitude_offset))
        else $error("tuning not seeded by offset");
    a_zero_floor: assert property (autoscale
        && user_amplitude_offset == 8'h00 |-> next_amp >= lower_thr)
        else $error("amplitude below floor at zero offset");
    a_below_floor: assert property (autoscale
        && user_amplitude_offset != 8'h00 && raw_amp <= 11'sh000
        |-> next_amp == 8'h00)
        else $error("low duty blocked with nonzero offset");
    a_ff_select: assert property (ce && !autoscale ##1 ce && !autoscale
        |=> amp == $past(base))
        else $error("feed-forward amplitude not selected");
    a_grad_track: assert property (ce && !autograd
        |=> learned_gradient == $past(user_gradient))
        else $error("gradient does not track user value");
    a_grad_pace: assert property (autograd && $past(autograd)
        && $changed(learned_gradient) |-> $past(full_step && ce
        && step_cnt == `CAS_STEPS_PER_GRAD))
        else $error("gradient moved off the eighth step");
    a_auto_unused: assert property (ce && req && !wb_ack_o && !wb_we_i
        && wb_adr_i[11:0] == {2'b00, `CAS_IDX_AUTO, 2'b00}
        |=> wb_dat_o[31:24] == 8'h00 && wb_dat_o[15:8] == 8'h00)
        else $error("unused status bits not zero");
    a_ro_ignore: assert property (ce && wr && idx == `CAS_IDX_AUTO
        && !pif.tick && autoscale && autoscale_q
        |=> $stable(learned_offset))
        else $error("status write changed learned offset");

    c_autoscale_on: cover property (autoscale && !autoscale_q);
    c_grad_step: cover property (autograd && $changed(learned_gradient));
    c_floor_hit: cover property (autoscale && next_amp == lower_thr);
    c_scale_read: cover property (wb_ack_o && idx == `CAS_IDX_SCALE);
endmodule : cas_regulator
